// File: hw/gpio_port_pkg.sv
// Constants, reset values and carrier types for the eight-pin GPIO port
package gpio_port_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int NPINS  = 8;
   localparam int NGRP   = 2;
   localparam int AW     = 12;

   // ----------------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------------
   localparam logic [9:0] IDX_DATA = 10'h000;
   localparam logic [9:0] IDX_DIR  = 10'h001;
   localparam logic [9:0] IDX_OPT  = 10'h002;
   localparam logic [9:0] IDX_SENS = 10'h003;
   localparam logic [9:0] IDX_PEND = 10'h004;
   localparam int         IDX_LSB  = 2;

   // ----------------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR  = 8'h00;
   localparam logic [7:0] RST_OPT  = 8'h40;
   localparam logic [3:0] RST_SENS = 4'h0;
   localparam int         SENS_W   = 2;
   localparam int         SENS_LSB = 0;
   localparam int         PEND_LSB = 0;

   // Pins that feed each external interrupt group
   localparam logic [NGRP-1:0][7:0] GRP_MASK = {8'hF0, 8'h0F};

   // ----------------------------------------------------------------------
   // Interrupt sensitivity encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] SENS_RISE     = 2'h1;
   localparam logic [1:0] SENS_FALL     = 2'h2;
   localparam logic [1:0] SENS_BOTH     = 2'h3;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
   } pin_drive_t;

   typedef struct packed {
      logic [7:0] en;
      logic [7:0] val;
      logic [7:0] od;
   } alt_req_t;

   typedef struct packed {
      logic [7:0]                 data;
      logic [7:0]                 dir;
      logic [7:0]                 opt;
      logic [NGRP-1:0][1:0]       sens;
      logic [NGRP-1:0]            pend;
      logic [NGRP-1:0]            grp_prev;
      logic [7:0]                 sync1;
      logic [7:0]                 sync2;
      logic [31:0]                prdata;
      logic                       pslverr;
      pin_drive_t                 drv;
   } port_state_t;

   localparam port_state_t RST_STATE = '{
      data:     RST_DATA,
      dir:      RST_DIR,
      opt:      RST_OPT,
      sens:     RST_SENS,
      grp_prev: 2'h3,
      default:  '0
   };

endpackage

// File: hw/gpio_port.sv
// Eight-pin GPIO port with APB registers, external interrupt groups and alternate functions
`timescale 1ns/1ps

module gpio_port
   import gpio_port_pkg::*;
(
   // Clock, reset, enable
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [AW-1:0]    paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Pins
   input  wire logic [7:0]       pin_in,
   output pin_drive_t            pin_drv,
   // Alternate functions
   input  wire alt_req_t         alt_req,
   output logic      [7:0]       alt_in,
   // External interrupt requests to the processor
   output logic      [NGRP-1:0]  irq_req,
   input  wire logic [NGRP-1:0]  irq_ack
);

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------

   // Register index is reused by the read mux, write mux and error check
   function automatic logic idx_mapped(input logic [9:0] idx);
      idx_mapped = (idx == IDX_DATA) || (idx == IDX_DIR) || (idx == IDX_OPT) ||
                   (idx == IDX_SENS) || (idx == IDX_PEND);
   endfunction

   // Group detector input: enabled pins ANDed, disabled ones read as one
   function automatic logic grp_in(input logic [7:0] en,
                                   input logic [7:0] mask,
                                   input logic [7:0] lvl);
      grp_in = &(~(en & mask) | lvl);
   endfunction

   // ----------------------------------------------------------------------
   // State and combinational terms
   // ----------------------------------------------------------------------
   port_state_t          st;
   port_state_t          nx;
   logic [9:0]           reg_idx;
   logic                 apb_setup;
   logic                 apb_wr;
   logic [7:0]           irq_en;
   logic [7:0]           rd_data;
   logic [NGRP-1:0]      gin;
   logic [NGRP-1:0]      set_ev;
   logic [NGRP-1:0]      sens_chg;

   // Bus phase decode
   assign reg_idx   = paddr[AW-1:IDX_LSB];
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;

   // Input with interrupt: direction clear and option set
   assign irq_en    = ~st.dir & st.opt;

   // Data read: latch for outputs, peripheral output or pin level otherwise
   assign rd_data   = (st.dir & st.data) |
                      (~st.dir & alt_req.en & alt_req.val) |
                      (~st.dir & ~alt_req.en & st.sync2);

   // Per-group combine, edge detection and sensitivity change
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      logic rise;
      logic fall;
      assign gin[g] = grp_in(irq_en, GRP_MASK[g], st.sync2);
      assign rise   = gin[g] & ~st.grp_prev[g];
      assign fall   = ~gin[g] & st.grp_prev[g];
      always_comb begin
         case (st.sens[g])
            SENS_FALL_LOW: set_ev[g] = ~gin[g];
            SENS_RISE:     set_ev[g] = rise;
            SENS_FALL:     set_ev[g] = fall;
            SENS_BOTH:     set_ev[g] = rise | fall;
            default:       set_ev[g] = 1'b0;
         endcase
      end
      assign sens_chg[g] = apb_wr && (reg_idx == IDX_SENS) &&
                           (pwdata[SENS_LSB+SENS_W*g +: SENS_W] != st.sens[g]);
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      nx = st;

      // Two flops on every pin; only the second stage is used downstream
      nx.sync1 = pin_in;
      nx.sync2 = st.sync1;

      // Register writes; the pending register is read-only
      if (apb_wr) begin
         case (reg_idx)
            IDX_DATA: nx.data = pwdata[7:0];
            IDX_DIR:  nx.dir  = pwdata[7:0];
            IDX_OPT:  nx.opt  = pwdata[7:0];
            IDX_SENS: nx.sens = pwdata[SENS_LSB +: SENS_W*NGRP];
            default:  nx.data = st.data;
         endcase
      end

      // Read data and error captured in setup, presented in access
      nx.pslverr = 1'b0;
      if (apb_setup) begin
         nx.pslverr = ~idx_mapped(reg_idx);
         case (reg_idx)
            IDX_DATA: nx.prdata = {24'h000000, rd_data};
            IDX_DIR:  nx.prdata = {24'h000000, st.dir};
            IDX_OPT:  nx.prdata = {24'h000000, st.opt};
            IDX_SENS: nx.prdata = {28'h0000000, st.sens};
            IDX_PEND: nx.prdata = {30'h00000000, st.pend};
            default:  nx.prdata = 32'h00000000;
         endcase
      end

      // Pending latches: a sensitivity change clears outright, otherwise
      // a new event beats a vector-fetch clear in the same cycle
      for (int g = 0; g < NGRP; g++) begin
         nx.grp_prev[g] = gin[g];
         if (sens_chg[g]) begin
            nx.pend[g] = 1'b0;
         end else if (set_ev[g]) begin
            nx.pend[g] = 1'b1;
         end else if (irq_ack[g]) begin
            nx.pend[g] = 1'b0;
         end
      end

      // Pin drivers per bit; peripheral output outranks the registers
      for (int i = 0; i < NPINS; i++) begin
         if (alt_req.en[i]) begin
            nx.drv.out[i]  = alt_req.od[i] ? 1'b0 : alt_req.val[i];
            nx.drv.oe[i]   = alt_req.od[i] ? ~alt_req.val[i] : 1'b1;
            nx.drv.pull[i] = 1'b0;
         end else if (st.dir[i]) begin
            nx.drv.out[i]  = st.opt[i] & st.data[i];
            nx.drv.oe[i]   = st.opt[i] | ~st.data[i];
            nx.drv.pull[i] = 1'b0;
         end else begin
            nx.drv.out[i]  = 1'b0;
            nx.drv.oe[i]   = 1'b0;
            nx.drv.pull[i] = st.opt[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register; enable low freezes everything except a synchronous reset
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= RST_STATE;
      end else if (ce) begin
         st <= nx;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   // Zero-wait slave; stalls only while the enable is low
   assign pready  = ce;
   assign prdata  = st.prdata;
   assign pslverr = st.pslverr;
   assign pin_drv = st.drv;
   // Peripherals see the synchronised pad level, for an output as well, never the latch itself
   assign alt_in  = st.sync2;
   assign irq_req = st.pend;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || !ce);

   sequence s_rd_data;
      apb_setup && !pwrite && (reg_idx == IDX_DATA);
   endsequence

   sequence s_wr_data;
      apb_wr && (reg_idx == IDX_DATA);
   endsequence

   // Three settled samples out of reset, so reset-cleared stages never count
   sequence s_pin_steady;
      (!srst && $stable(pin_in)) [*3];
   endsequence

   AST_RD_INPUT: assert property (
      s_rd_data ##0 (st.dir == 8'h00 && alt_req.en == 8'h00)
      |=> prdata == {24'h000000, $past(st.sync2)})
      else $error("input read did not return synchronised pin");

   AST_RD_OUTPUT: assert property (
      s_rd_data ##0 (st.dir == 8'hFF) |=> prdata[7:0] == $past(st.data))
      else $error("output read did not return latch");

   AST_RD_ALT: assert property (
      s_rd_data |=> (prdata[7:0] & $past(~st.dir & alt_req.en))
                    == $past(alt_req.val & ~st.dir & alt_req.en))
      else $error("input read did not return peripheral output");

   AST_WR_INPUT: assert property (
      s_wr_data ##0 (st.dir == 8'h00 && alt_req.en == 8'h00)
      |=> (pin_drv.oe == 8'h00) [*2])
      else $error("data write drove an input pin");

   AST_PULLUP: assert property (
      !srst |=> pin_drv.pull == $past(~st.dir & st.opt & ~alt_req.en))
      else $error("pull-up not tied to floating or pull-up input mode");

   AST_OD_FLOAT: assert property (
      1'b1 |=> (pin_drv.oe & $past(st.dir & ~st.opt & st.data & ~alt_req.en)) == 8'h00)
      else $error("open-drain one did not float");

   AST_DRIVE_LOW: assert property (
      1'b1 |=> ((pin_drv.oe & ~pin_drv.out) & $past(st.dir & ~st.data & ~alt_req.en))
               == $past(st.dir & ~st.data & ~alt_req.en))
      else $error("output zero not driven low");

   AST_ALT_PP: assert property (
      1'b1 |=> (pin_drv.oe & $past(alt_req.en & ~alt_req.od))
               == $past(alt_req.en & ~alt_req.od))
      else $error("peripheral push-pull output not driven");

   AST_SYNC: assert property (
      s_pin_steady |-> st.sync2 == pin_in)
      else $error("synchroniser not settled after two cycles");

   for (genvar g = 0; g < NGRP; g++) begin : g_ast
      AST_GRP_ONE: assert property (
         ((irq_en & GRP_MASK[g]) == 8'h00) |-> gin[g])
         else $error("disabled group detector input not high");

      AST_GRP_AND: assert property (
         !gin[g] |-> ((irq_en & GRP_MASK[g] & ~st.sync2) != 8'h00))
         else $error("group low without an enabled low pin");

      AST_RISE_SET: assert property (
         (st.sens[g] == SENS_RISE) && gin[g] && !st.grp_prev[g] && !sens_chg[g]
         |=> irq_req[g])
         else $error("rising edge did not set pending request");

      AST_SENS_CLR: assert property (
         sens_chg[g] |=> !irq_req[g])
         else $error("sensitivity change left request pending");

      AST_ACK_CLR: assert property (
         irq_ack[g] && !set_ev[g] && !sens_chg[g] |=> !irq_req[g])
         else $error("vector fetch did not clear request");
   end

endmodule

// File: verification/pin_model.sv
// Model of the pads and the outside world that loads the eight port pins
`timescale 1ns/1ps

module pin_model
   import gpio_port_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Port drive and outside drivers
   input  wire pin_drive_t drv,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // Resolved pad level
   output logic      [7:0] lvl
);
   // ----------------------------------------------------------------
   // Pad resolution
   // ----------------------------------------------------------------
   // A floating pad toggles so a stale level can never pass for a read
   initial lvl = 8'hFF;
   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (drv.oe[i]) begin
            lvl[i] <= drv.out[i];
         end else if (ext_en[i]) begin
            lvl[i] <= ext_val[i];
         end else if (drv.pull[i]) begin
            lvl[i] <= 1'b1;
         end else begin
            lvl[i] <= ~lvl[i];
         end
      end
   end
endmodule

// File: verification/tb_top.sv
// Self-checking bench of the GPIO port over APB, pins and interrupt lines
`timescale 1ns/1ps

module tb_top
   import gpio_port_pkg::*;
;
   logic clk, srst, ce, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0] paddr;
   logic [31:0]   pwdata, prdata;
   logic [7:0]    lvl, alt_in, ext_en, ext_val;
   logic [1:0]    irq_req, irq_ack;
   pin_drive_t    pin_drv;
   alt_req_t      alt_req;
   int            fails, comparisons, cycles;

   gpio_port u_dut (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(lvl), .pin_drv(pin_drv), .alt_req(alt_req),
      .alt_in(alt_in), .irq_req(irq_req), .irq_ack(irq_ack));
   pin_model u_pins (.clk(clk), .drv(pin_drv), .ext_en(ext_en), .ext_val(ext_val), .lvl(lvl));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 5000) begin
         fails++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; answer taken at the rising edge that samples pready high
   task automatic xfer(logic w, logic [AW-1:0] a, logic [31:0] wd,
                       output logic [31:0] rv, output logic er);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [AW-1:0] a, logic [31:0] d);
      logic [31:0] v;
      logic        e;
      xfer(1'b1, a, d, v, e);
   endtask
   task automatic rdc(string nm, logic [AW-1:0] a, logic [31:0] x);
      logic [31:0] v;
      logic        e;
      xfer(1'b0, a, 32'h0, v, e);
      chk(nm, x, v);
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic pins(logic [7:0] v);
      @(posedge clk);
      ext_val <= v;
      wt(5);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] v;
      logic        e;
      rdc("data", 12'h000, 32'h00);
      rdc("dir", 12'h004, 32'h00);
      rdc("opt", 12'h008, 32'h40);
      rdc("sens", 12'h00C, 32'h0);
      xfer(1'b0, 12'h014, 32'h0, v, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test reset done");
   endtask
   task automatic t_out();
      @(posedge clk);
      ext_val <= 8'h00;
      wr(12'h000, 32'hA5);
      wr(12'h008, 32'hF0);
      wr(12'h004, 32'hFF);
      wt(3);
      chk("oe", 32'hFA, pin_drv.oe);
      chk("out", 32'hA0, pin_drv.out & pin_drv.oe);
      rdc("latch read", 12'h000, 32'hA5);
      $display("test output done");
   endtask
   task automatic t_in();
      wr(12'h004, 32'h00);
      wr(12'h008, 32'h00);
      pins(8'h3C);
      rdc("pin read", 12'h000, 32'h3C);
      wr(12'h000, 32'hFF);
      wr(12'h008, 32'h0F);
      wt(3);
      chk("oe input", 32'h00, pin_drv.oe);
      chk("pull", 32'h0F, pin_drv.pull);
      $display("test input done");
   endtask
   task automatic ack0();
      @(posedge clk);
      irq_ack <= 2'h1;
      @(posedge clk);
      irq_ack <= 2'h0;
      wt(2);
   endtask
   task automatic t_irq();
      pins(8'hFF);
      wr(12'h00C, 32'h1);
      wr(12'h008, 32'h41);
      wt(4);
      pins(8'hFE);
      chk("no fall irq", 32'h0, irq_req[0]);
      pins(8'hFF);
      chk("rise irq", 32'h1, irq_req[0]);
      ack0();
      chk("ack clear", 32'h0, irq_req[0]);
      pins(8'hFE);
      pins(8'hFF);
      wr(12'h00C, 32'h3);
      wt(2);
      chk("sens clear", 32'h0, irq_req[0]);
      wr(12'h00C, 32'h1);
      pins(8'hFD);
      wr(12'h008, 32'h43);
      pins(8'hFC);
      pins(8'hFD);
      chk("and mask", 32'h0, irq_req[0]);
      pins(8'hFF);
      chk("and rise", 32'h1, irq_req[0]);
      pins(8'hFE);
      wr(12'h008, 32'h41);
      ack0();
      wr(12'h008, 32'h40);
      wt(5);
      chk("disable edge", 32'h1, irq_req[0]);
      wr(12'h008, 32'h41);
      ack0();
      wr(12'h00C, 32'h2);
      wr(12'h008, 32'h40);
      wt(5);
      chk("safe disable", 32'h0, irq_req[0]);
      wr(12'h00C, 32'h1);
      $display("test interrupt done");
   endtask
   task automatic t_alt();
      wr(12'h000, 32'h08);
      wr(12'h008, 32'h08);
      wr(12'h004, 32'h08);
      @(posedge clk);
      ext_val <= 8'h00;
      alt_req <= '{en: 8'h04, val: 8'h04, od: 8'h04};
      wt(5);
      chk("od float", 32'h0, pin_drv.oe[2]);
      rdc("alt read", 12'h000, 32'h0C);
      chk("alt_in out pin", 32'h1, alt_in[3]);
      @(posedge clk);
      alt_req <= '{en: 8'h04, val: 8'h04, od: 8'h00};
      wt(3);
      chk("alt drive", 32'h3, {pin_drv.oe[2], pin_drv.out[2]});
      wr(12'h000, 32'h00);
      wt(5);
      chk("alt_in low", 32'h0, alt_in[3]);
      $display("test alternate done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      fails = 0; comparisons = 0; cycles = 0;
      srst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; irq_ack = '0; alt_req = '0;
      ext_en = 8'hFF; ext_val = 8'hFF;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_out();
      t_in();
      t_irq();
      t_alt();
      end_sim();
   end
endmodule
